// ---- hw/mlpe_top.v ----
// Purpose: Event selection and counting for the performance counters of the
//          agent joining the on-die mesh to the inter-socket coherent link.
// Assumes: One uncore clock; event inputs are synchronous single-cycle levels.
// Notes:   Four counters, each with a control word and a readable count.
//
// What this block does
// - Code 0x01 counts every uncore clock.
// - Enable and freeze act after short pipeline.
// - Code 0x22 counts agent request credit empty.
// - Code 0x2b counts direct to core sends.
// - Code 0x2a counts direct to utility sends.
// - Code 0x23 counts PCIe agent data credits empty.
// - Mask bits 0-4 pick I/O stack credits.
// - Mask bits 5-6 pick noncoherent standard credits.
// - Code 0x3e counts flits with several slots.
// - Mask bits 0-5 pick ring slot classes.
// - Code 0x4b counts lost net0 arbitration.
// - Code 0x4c counts lost net1 arbitration.
// - Mask bits 0-6 pick lost message classes.
`timescale 1ns/1ns
`include "mlpe_map.vh"
module mlpe_top #(
  parameter CTR_W = 32,
  parameter N_CTR = 4
) (
  // Clock and reset.
  input  wire                    CLK_IN,
  input  wire                    RST_B_IN,
  // Register port.
  input  wire [`MLPE_ADDR_W-1:0] ADDR_IN,
  input  wire [31:0]             WDATA_IN,
  input  wire                    WR_IN,
  input  wire                    RD_IN,
  output reg  [31:0]             RDATA_OUT,
  // Global freeze from the utility unit.
  input  wire                    FREEZE_IN,
  // Agent request credit empty: adaptive, writeback, request, snoop.
  input  wire [3:0]              AGENT_REQUEST_CREDIT_EMPTY_IN,
  // Single-cycle send events.
  input  wire                    DIRECT_TO_CORE_SENT_IN,
  input  wire                    DIRECT_TO_UTILITY_SENT_IN,
  // PCIe mesh agent data credit empty per destination class.
  input  wire [6:0]              PCIE_AGENT_DATA_CREDIT_EMPTY_IN,
  // Received flit: valid, slots 0-2 full, and slot classes present.
  input  wire                    FLIT_VALID_IN,
  input  wire [2:0]              FLIT_SLOT_FULL_IN,
  input  wire [5:0]              MULTI_SLOT_FLIT_RECEIVED_IN,
  // Lost ingress arbitration per message class.
  input  wire [6:0]              INGRESS_ARB_LOST_NET0_IN,
  input  wire [6:0]              INGRESS_ARB_LOST_NET1_IN,
  // Sticky wrap flags of the counters.
  output reg  [N_CTR-1:0]        COUNTER_WRAP_OUT
);

  // Word index of the access and the decoded register group.
  wire [5:0] word_idx;
  assign word_idx = ADDR_IN[7:2];

  // Group bases at full width, so that their upper nibbles can be compared.
  localparam [7:0] CTL_BASE = `MLPE_CTL_BASE;
  localparam [7:0] CNT_BASE = `MLPE_CNT_BASE;

  // Group selects; counter index lives in the low two index bits.
  wire       sel_ctl;
  wire       sel_cnt;
  wire       sel_wrap;
  wire       sel_hit;
  wire [1:0] sel_n;
  assign sel_ctl  = (ADDR_IN[7:4] == CTL_BASE[7:4]) &&
                    (ADDR_IN[1:0] == 2'h0);
  assign sel_cnt  = (ADDR_IN[7:4] == CNT_BASE[7:4]) &&
                    (ADDR_IN[1:0] == 2'h0);
  assign sel_wrap = (ADDR_IN == `MLPE_WRAP_OFS);
  assign sel_hit  = (ADDR_IN == `MLPE_HIT_OFS);
  assign sel_n    = word_idx[1:0];

  // Control words, keeping the writable bits that software wrote.
  reg [31:0] ctl_r [0:N_CTR-1];

  // Enable bits of all counters, and their delayed copies.
  wire [N_CTR-1:0] en_now;
  reg  [N_CTR-1:0] en_dly_r [0:`MLPE_CTL_DLY-1];

  // Freeze pipeline, same depth as the enable path.
  reg  [`MLPE_CTL_DLY-1:0] frz_r;

  // Per-counter hit, increment, load, wrap and clear.
  wire [N_CTR-1:0] hit;
  wire [N_CTR-1:0] inc;
  wire [N_CTR-1:0] load;
  wire [N_CTR-1:0] wrap;
  wire [N_CTR-1:0] ctl_clr;

  // Counter values, packed for the read mux.
  wire [CTR_W-1:0] cnt [0:N_CTR-1];

  // Last-cycle hits and sticky wrap flags.
  reg  [N_CTR-1:0] hit_r;
  reg  [N_CTR-1:0] wrap_r;
  reg  [N_CTR-1:0] wrap_nxt;

  // Read data next value.
  reg  [31:0] rdata_nxt;

  // Loaded value cut to the counter width.
  wire [CTR_W-1:0] load_val;
  assign load_val = WDATA_IN[CTR_W-1:0];

  integer k;

  // Control word writes; only documented fields are kept, clear is a pulse.
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (k = 0; k < N_CTR; k = k + 1) begin
        ctl_r[k] <= `MLPE_CTL_RST;
      end
    end else if (WR_IN && sel_ctl) begin
      ctl_r[sel_n] <= WDATA_IN & `MLPE_CTL_WMASK;
    end
  end

  // Enable and freeze take a fixed number of clocks to reach the counters.
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      for (k = 0; k < `MLPE_CTL_DLY; k = k + 1) begin
        en_dly_r[k] <= {N_CTR{1'b0}};
      end
      frz_r <= {`MLPE_CTL_DLY{1'b0}};
    end else begin
      en_dly_r[0] <= en_now;
      for (k = 1; k < `MLPE_CTL_DLY; k = k + 1) begin
        en_dly_r[k] <= en_dly_r[k-1];
      end
      frz_r <= {frz_r[`MLPE_CTL_DLY-2:0], FREEZE_IN};
    end
  end

  // One selector and one counter per slot.
  genvar g;
  generate
    for (g = 0; g < N_CTR; g = g + 1) begin : ctr
      // Enable straight from the control word.
      assign en_now[g] = ctl_r[g][`MLPE_EN_BIT];

      // Software may clear the count by writing the clear bit.
      assign ctl_clr[g] = WR_IN && sel_ctl && (sel_n == g) &&
                          WDATA_IN[`MLPE_CLR_BIT];

      // A write to the count word, or a clear, loads the counter.
      assign load[g] = ctl_clr[g] || (WR_IN && sel_cnt && (sel_n == g));

      // Increment only when enabled, unfrozen and matching.
      assign inc[g] = en_dly_r[`MLPE_CTL_DLY-1][g] &&
                      !frz_r[`MLPE_CTL_DLY-1] && hit[g];

      mlpe_event_sel u_sel (
        .event_code_in (ctl_r[g][`MLPE_EV_MSB:`MLPE_EV_LSB]),
        .umask_in      (ctl_r[g][`MLPE_UM_MSB:`MLPE_UM_LSB]),
        .agent_cred_in (AGENT_REQUEST_CREDIT_EMPTY_IN),
        .to_core_in    (DIRECT_TO_CORE_SENT_IN),
        .to_util_in    (DIRECT_TO_UTILITY_SENT_IN),
        .pcie_cred_in  (PCIE_AGENT_DATA_CREDIT_EMPTY_IN),
        .flit_valid_in (FLIT_VALID_IN),
        .flit_slot_in  (FLIT_SLOT_FULL_IN),
        .flit_class_in (MULTI_SLOT_FLIT_RECEIVED_IN),
        .lost0_in      (INGRESS_ARB_LOST_NET0_IN),
        .lost1_in      (INGRESS_ARB_LOST_NET1_IN),
        .hit_out       (hit[g])
      );

      mlpe_counter #(
        .CTR_W (CTR_W)
      ) u_cnt (
        .clk_in      (CLK_IN),
        .rst_b_in    (RST_B_IN),
        .inc_in      (inc[g]),
        .load_in     (load[g]),
        .load_val_in (ctl_clr[g] ? {CTR_W{1'b0}} : load_val),
        .count_out   (cnt[g]),
        .wrap_out    (wrap[g])
      );
    end
  endgenerate

  // Sticky wrap flags: a new wrap wins over a write-one clear.
  always @* begin
    wrap_nxt = wrap_r;
    if (WR_IN && sel_wrap) begin
      wrap_nxt = wrap_r & ~WDATA_IN[N_CTR-1:0];
    end
    wrap_nxt = wrap_nxt | wrap;
  end

  // Status flops: wrap flags, and the last-cycle hit of each counter.
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      wrap_r           <= {N_CTR{1'b0}};
      COUNTER_WRAP_OUT <= {N_CTR{1'b0}};
      hit_r            <= {N_CTR{1'b0}};
    end else begin
      wrap_r           <= wrap_nxt;
      COUNTER_WRAP_OUT <= wrap_nxt;
      hit_r            <= hit;
    end
  end

  // Count word zero-padded to the bus width.
  wire [CTR_W+31:0] cnt_pad;
  assign cnt_pad = {32'h00000000, cnt[sel_n]};

  // Read mux; unmapped addresses read as zero.
  always @* begin
    rdata_nxt = 32'h00000000;
    if (sel_ctl) begin
      rdata_nxt = ctl_r[sel_n];
    end else if (sel_cnt) begin
      rdata_nxt = cnt_pad[31:0];
    end else if (sel_wrap) begin
      rdata_nxt[N_CTR-1:0] = wrap_r;
    end else if (sel_hit) begin
      rdata_nxt[N_CTR-1:0] = hit_r;
    end
  end

  // Read data stands for the one cycle after the strobe, zero otherwise.
  always @(posedge CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      RDATA_OUT <= 32'h00000000;
    end else if (RD_IN) begin
      RDATA_OUT <= rdata_nxt;
    end else begin
      RDATA_OUT <= 32'h00000000;
    end
  end

endmodule

// ---- hw/mlpe_map.vh ----
// Purpose: Register map, field positions and event codes for the mesh link
//          performance event selection block.
// Assumes: Registers are 32-bit words at byte addresses on a plain port.
// Notes:   Definitions only; included by bare name.
`ifndef MLPE_MAP_VH
`define MLPE_MAP_VH

// Register bus address width in bits.
`define MLPE_ADDR_W 8
// Control registers, one word per counter, counter n at base plus 4n.
`define MLPE_CTL_BASE 8'h00
// Counter value registers, one word per counter.
`define MLPE_CNT_BASE 8'h10
// Sticky wrap flags, write one to clear.
`define MLPE_WRAP_OFS 8'h20
// Last-cycle event match of each counter, read only.
`define MLPE_HIT_OFS 8'h24

// Control register fields.
`define MLPE_EV_LSB 0
`define MLPE_EV_MSB 7
`define MLPE_UM_LSB 8
`define MLPE_UM_MSB 15
`define MLPE_CLR_BIT 17
`define MLPE_EN_BIT 22
// Writable control bits; all others read as zero.
`define MLPE_CTL_WMASK 32'h0040FFFF
`define MLPE_CTL_RST 32'h00000000

// Event codes.
`define MLPE_EV_CYCLE 8'h01
`define MLPE_EV_AGENT_CRED 8'h22
`define MLPE_EV_PCIE_CRED 8'h23
`define MLPE_EV_TO_UTIL 8'h2A
`define MLPE_EV_TO_CORE 8'h2B
`define MLPE_EV_MULTI_SLOT 8'h3E
`define MLPE_EV_LOST_NET0 8'h4B
`define MLPE_EV_LOST_NET1 8'h4C

// Pipeline stages that enable and freeze controls pass before acting.
`define MLPE_CTL_DLY 2

`endif

// ---- hw/mlpe_event_sel.v ----
// Purpose: Decodes one counter's event code and sub-event mask into a hit.
// Assumes: All event inputs are single-cycle levels in the uncore clock.
// Notes:   Purely combinational; one instance per counter.
`timescale 1ns/1ns
`include "mlpe_map.vh"
module mlpe_event_sel (
  // Selection.
  input  wire [7:0] event_code_in,
  input  wire [7:0] umask_in,
  // Event conditions.
  input  wire [3:0] agent_cred_in,
  input  wire       to_core_in,
  input  wire       to_util_in,
  input  wire [6:0] pcie_cred_in,
  input  wire       flit_valid_in,
  input  wire [2:0] flit_slot_in,
  input  wire [5:0] flit_class_in,
  input  wire [6:0] lost0_in,
  input  wire [6:0] lost1_in,
  // Result.
  output reg        hit_out
);

  // A flit counts as multi-slot when at least two of slots 0-2 are full.
  wire multi_slot;
  assign multi_slot = (flit_slot_in[0] & flit_slot_in[1]) |
                      (flit_slot_in[0] & flit_slot_in[2]) |
                      (flit_slot_in[1] & flit_slot_in[2]);

  // Pick the condition for the code; any masked sub-event raises the hit, but 0x3e also needs a valid multi-slot flit.
  always @* begin
    case (event_code_in)
      `MLPE_EV_CYCLE: begin
        hit_out = 1'b1;
      end
      `MLPE_EV_AGENT_CRED: begin
        hit_out = |(agent_cred_in & umask_in[3:0]);
      end
      `MLPE_EV_TO_CORE: begin
        hit_out = to_core_in;
      end
      `MLPE_EV_TO_UTIL: begin
        // Kept although obsolete, so old software still reads sane values.
        hit_out = to_util_in;
      end
      `MLPE_EV_PCIE_CRED: begin
        // Bit 0 is the shared stack pair, 1-4 stacks 2-5, 5 all standard, 6 selected.
        hit_out = |(pcie_cred_in & umask_in[6:0]);
      end
      `MLPE_EV_MULTI_SLOT: begin
        hit_out = flit_valid_in & multi_slot &
                  (|(flit_class_in & umask_in[5:0]));
      end
      `MLPE_EV_LOST_NET0: begin
        hit_out = |(lost0_in & umask_in[6:0]);
      end
      `MLPE_EV_LOST_NET1: begin
        hit_out = |(lost1_in & umask_in[6:0]);
      end
      default: begin
        // Unknown codes never count.
        hit_out = 1'b0;
      end
    endcase
  end

endmodule

// ---- hw/mlpe_counter.v ----
// Purpose: One event counter with software load and a wrap pulse.
// Assumes: Increment is at most one per clock.
// Notes:   A software load takes priority over an increment in the same cycle.
`timescale 1ns/1ns
module mlpe_counter #(
  parameter CTR_W = 32
) (
  // Clock and reset.
  input  wire             clk_in,
  input  wire             rst_b_in,
  // Control.
  input  wire             inc_in,
  input  wire             load_in,
  input  wire [CTR_W-1:0] load_val_in,
  // Status.
  output reg  [CTR_W-1:0] count_out,
  output reg              wrap_out
);

  // Count up by one, or take the loaded value; flag the roll past all ones.
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      count_out <= {CTR_W{1'b0}};
      wrap_out  <= 1'b0;
    end else if (load_in) begin
      count_out <= load_val_in;
      wrap_out  <= 1'b0;
    end else if (inc_in) begin
      count_out <= count_out + {{(CTR_W-1){1'b0}}, 1'b1};
      wrap_out  <= &count_out;
    end else begin
      wrap_out  <= 1'b0;
    end
  end

endmodule

// ---- verification/mlpe_top_assertions.sv ----
// Purpose: Port-level checks for the mesh link event selection block.
// Assumes: One uncore clock; reset is asynchronous and active low.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/1ns
`include "mlpe_map.vh"
module mlpe_chk #(
  parameter CTR_W = 32,
  parameter N_CTR = 4
) (
  // Clock, reset and register port.
  input wire                    CLK_IN,
  input wire                    RST_B_IN,
  input wire [`MLPE_ADDR_W-1:0] ADDR_IN,
  input wire                    WR_IN,
  input wire                    RD_IN,
  input wire [31:0]             RDATA_OUT,
  // Freeze and wrap flags.
  input wire                    FREEZE_IN,
  input wire [N_CTR-1:0]        COUNTER_WRAP_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  // Address classes of the register map.
  wire cnt_a = (ADDR_IN[7:4] == 4'h1) && (ADDR_IN[1:0] == 2'h0);
  wire ctl_a = (ADDR_IN[7:4] == 4'h0) && (ADDR_IN[1:0] == 2'h0);
  wire bad_a = (ADDR_IN > 8'h24) || (ADDR_IN[1:0] != 2'h0);
  wire flg_a = (ADDR_IN == 8'h20) || (ADDR_IN == 8'h24);
  chk_rdata_quiet: assert property (!RD_IN |=> RDATA_OUT == 32'h0)
    else $error("read data not zero outside a read");
  chk_ctl_fields: assert property (RD_IN && ctl_a |=> (RDATA_OUT & ~`MLPE_CTL_WMASK) == 32'h0)
    else $error("control read shows unwritable bits");
  chk_unmapped_zero: assert property (RD_IN && bad_a |=> RDATA_OUT == 32'h0)
    else $error("unmapped read not zero");
  chk_flag_width: assert property (RD_IN && flg_a |=> (RDATA_OUT >> N_CTR) == 32'h0)
    else $error("flag read wider than counter count");
  chk_wrap_read: assert property (RD_IN && ADDR_IN == 8'h20 |=>
    RDATA_OUT[N_CTR-1:0] == $past(COUNTER_WRAP_OUT))
    else $error("wrap read differs from wrap flags");
  chk_wrap_fall: assert property (|($past(COUNTER_WRAP_OUT) & ~COUNTER_WRAP_OUT) |->
    $past(WR_IN && ADDR_IN == 8'h20))
    else $error("wrap flag dropped without a clear write");
  chk_cnt_step: assert property (RD_IN && cnt_a ##1 RD_IN && $stable(ADDR_IN) |=>
    (RDATA_OUT - $past(RDATA_OUT)) <= 32'h1)
    else $error("counter rose by more than one per clock");
  chk_frozen_hold: assert property (FREEZE_IN [*4] ##0 RD_IN && cnt_a ##1
    RD_IN && FREEZE_IN && $stable(ADDR_IN) |=> RDATA_OUT == $past(RDATA_OUT))
    else $error("counter moved while frozen");
endmodule
bind mlpe_top mlpe_chk #(.CTR_W(CTR_W), .N_CTR(N_CTR)) i_chk (.CLK_IN(CLK_IN),
  .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
  .RDATA_OUT(RDATA_OUT), .FREEZE_IN(FREEZE_IN), .COUNTER_WRAP_OUT(COUNTER_WRAP_OUT));

// ---- verification/tb_mlpe_top.sv ----
// Purpose: Self-checking bench for the event selection block.
// Assumes: Register port with read data one cycle after the strobe.
// Notes:   Counter 0 carries the event tests; all counters see ticks.
`timescale 1ns/1ns
module tb_mlpe_top;
  reg         CLK_IN = 1'b0;
  reg         RST_B_IN = 1'b0;
  reg  [7:0]  ADDR_IN = 8'h0;
  reg  [31:0] WDATA_IN = 32'h0;
  reg         WR_IN = 1'b0;
  reg         RD_IN = 1'b0;
  reg         FREEZE_IN = 1'b0;
  reg  [2:0]  slot_r = 3'h3;           // Slots 0 and 1 full by default.
  reg  [6:0]  ev [0:6];                // One event vector per event kind.
  wire [31:0] RDATA_OUT;
  wire [3:0]  COUNTER_WRAP_OUT;
  reg  [31:0] d1, d2;                  // Results of back-to-back reads.
  int         n_fail = 0, compares = 0, k, b, j;
  localparam logic [7:0] CODE [0:6] = '{8'h22, 8'h2B, 8'h2A, 8'h23, 8'h3E, 8'h4B, 8'h4C};
  localparam int WID [0:6] = '{4, 1, 1, 7, 6, 7, 7};
  mlpe_top i_dut (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN), .ADDR_IN(ADDR_IN),
    .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
    .FREEZE_IN(FREEZE_IN), .AGENT_REQUEST_CREDIT_EMPTY_IN(ev[0][3:0]),
    .DIRECT_TO_CORE_SENT_IN(ev[1][0]), .DIRECT_TO_UTILITY_SENT_IN(ev[2][0]),
    .PCIE_AGENT_DATA_CREDIT_EMPTY_IN(ev[3]), .FLIT_VALID_IN(|ev[4]),
    .FLIT_SLOT_FULL_IN(slot_r), .MULTI_SLOT_FLIT_RECEIVED_IN(ev[4][5:0]),
    .INGRESS_ARB_LOST_NET0_IN(ev[5]), .INGRESS_ARB_LOST_NET1_IN(ev[6]),
    .COUNTER_WRAP_OUT(COUNTER_WRAP_OUT));
  // The clock toggles every 50 ns, for a period of 100 ns.
  always #50 CLK_IN = ~CLK_IN;
  // One write cycle.
  task wr(input [7:0] a, input [31:0] d);
    @(posedge CLK_IN);
    WR_IN <= 1'b1;
    ADDR_IN <= a;
    WDATA_IN <= d;
    @(posedge CLK_IN);
    WR_IN <= 1'b0;
  endtask
  // Two reads back to back; d2 is the later value.
  task rd2(input [7:0] a);
    @(posedge CLK_IN);
    RD_IN <= 1'b1;
    ADDR_IN <= a;
    @(posedge CLK_IN);
    #1 d1 = RDATA_OUT;
    @(posedge CLK_IN);
    RD_IN <= 1'b0;
    #1 d2 = RDATA_OUT;
  endtask
  // Holds one event vector for three sampled clocks.
  task burst(input int e, input [6:0] v);
    @(posedge CLK_IN);
    ev[e] <= v;
    repeat (3) @(posedge CLK_IN);
    ev[e] <= 7'h0;
  endtask
  // Compares one value and counts the result.
  task chk(input string nm, input [31:0] e, input [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task conclude;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    #2000000;
    n_fail++;
    conclude;
  end
  // Main sequence.
  initial begin
    for (j = 0; j < 7; j++) ev[j] = 7'h0;
    repeat (4) @(posedge CLK_IN);
    RST_B_IN <= 1'b1;
    rd2(8'h00); chk("control reset", 32'h0, d2);
    rd2(8'h10); chk("count reset", 32'h0, d2);
    $display("test reset done");
    // Each mask bit of each event counts alone, after a cycle of noise on all others.
    for (k = 0; k < 7; k++) for (b = 0; b < WID[k]; b++) begin
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h00400000 | (32'h1 << (b + 8)) | CODE[k]);
      repeat (3) @(posedge CLK_IN);
      for (j = 0; j < 7; j++) ev[j] <= (j == k) ? ~(7'h1 << b) : 7'h7F;
      @(posedge CLK_IN);
      for (j = 0; j < 7; j++) ev[j] <= 7'h0;
      burst(k, 7'h1 << b);
      rd2(8'h10); chk("event count", 32'h3, d2);
    end
    $display("test event masks done");
    // A flit with one slot full and a disabled counter both stay at zero.
    slot_r <= 3'h1;
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h00403F3E);
    repeat (3) @(posedge CLK_IN);
    burst(4, 7'h3F);
    rd2(8'h10); chk("single slot", 32'h0, d2);
    wr(8'h00, 32'h0000012B);
    repeat (3) @(posedge CLK_IN);
    burst(1, 7'h1);
    rd2(8'h10); chk("disabled", 32'h0, d2);
    $display("test refusals done");
    // Clock ticks on every counter, then a freeze.
    for (k = 0; k < 4; k++) begin
      wr(8'(4 * k), 32'h00400001);
      repeat (3) @(posedge CLK_IN);
      rd2(8'(8'h10 + 4 * k)); chk("tick step", 32'h1, d2 - d1);
    end
    @(posedge CLK_IN);
    FREEZE_IN <= 1'b1;
    repeat (4) @(posedge CLK_IN);
    rd2(8'h10); chk("frozen step", 32'h0, d2 - d1);
    @(posedge CLK_IN);
    FREEZE_IN <= 1'b0;
    $display("test ticks done");
    // Wrap, sticky flag, clear by writing one.
    wr(8'h10, 32'hFFFFFFFE);
    repeat (6) @(posedge CLK_IN);
    rd2(8'h20); chk("wrap read", 32'h1, d2);
    chk("wrap port", 32'h1, {28'h0, COUNTER_WRAP_OUT});
    wr(8'h20, 32'h1);
    rd2(8'h20); chk("wrap cleared", 32'h0, d2);
    // Control field mask and unmapped places.
    wr(8'h04, 32'hFFFFFFFF);
    rd2(8'h04); chk("control mask", 32'h0040FFFF, d2);
    rd2(8'h30); chk("unmapped", 32'h0, d2);
    rd2(8'h11); chk("misaligned", 32'h0, d2);
    rd2(8'h24); chk("hit flags", 32'hD, d2);
    $display("test registers done");
    conclude;
  end
endmodule
